// ---- fsc_pkg.sv ----
// Package with constants and types for the flash status and configuration register block
// Contract
// R1 - Fail flag is read-only, set by failed/interrupted/protected array work, cleared by success.
// R2 - Three security lock bits S13-S11 start 0, set individually, never return to 0; here sys_rst_i clears them to 0.
// R3 - Complement bit S14 is writable, defaults 0, combines with block protect bits.
// R4 - Suspend flag S15 set by opcode 75H, cleared by 7AH or power cycle.
// R5 - Configuration read 15 accepted anytime; byte shifted out on serial output.
// R6 - Host should poll write-in-progress before new commands during a write cycle.
// R7 - Configuration bit 7 picks hold or reset pin function, only while quad enable 0.
// R8 - Configuration bits 4:3 select page size 256, 512, 1024 bytes; 11 reserved.
// R9 - Page size sets where the page program load address wraps to zero.
// R10 - Page erase 81h spans double page at 01, quadruple page at 10.
// R11 - Configuration bit 2 picks protection scheme; block locks read 1 after reset.
// R12 - Configuration bit 1 picks dummy clocks: dual 4/8, quad 6/10.
// R13 - With bit 0 set, pattern 00110100 drives each data line in dummy cycles.
// R14 - Status writes 01H/31H need the write enable latch set, else ignored.
// R15 - Status writes never change S15, S10, S1 and S0.
// R16 - Chip select must rise after 8 data bits, or 16 for 01H, else discarded.
// R17 - 01h with one byte writes low byte only; two bytes write both.
// R18 - Chip select rise starts timed write; busy flag 1 meanwhile; latch clears after.
// R19 - Status writes refused while hardware protected mode is in effect.
// R20 - Configuration write 11 needs write enable and exactly 8 data bits.
// R21 - Configuration write holds busy flag, then clears it and the write enable latch.
// R22 - Status layout: busy S0, latch S1, protect S6-S2, S7/S8 protect, quad S9.
// R23 - No status write accepted while the write enable latch is 0.
// R24 - Read status 05H returns low byte, 35H returns high byte.
// R25 - Reserved configuration bits 6 and 5 read 0 and ignore writes.
// R26 - Volatile configuration bits return to 0 at every power-up.
package fsc_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_STAT_HI = 8'h31;
  localparam logic [7:0] OP_WRITE_CONFIG  = 8'h11;
  localparam logic [7:0] OP_READ_STAT_LO  = 8'h05;
  localparam logic [7:0] OP_READ_STAT_HI  = 8'h35;
  localparam logic [7:0] OP_READ_CONFIG   = 8'h15;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7A;

  // Frame lengths in serial bits
  localparam logic [5:0] LEN_OPCODE   = 6'h08;
  localparam logic [5:0] LEN_ONE_BYTE = 6'h10;
  localparam logic [5:0] LEN_TWO_BYTE = 6'h18;
  localparam logic [5:0] LEN_MAX      = 6'h3F;
  localparam logic [5:0] LEN_FIRST    = 6'h01;

  // Timing
  localparam int CLK_PERIOD_NS          = 100;
  localparam int REGISTER_WRITE_TIME_US = 5;
  localparam int WRITE_CYCLES = (REGISTER_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  // Derived values
  localparam logic [9:0] WRAP_256  = 10'h0FF;
  localparam logic [9:0] WRAP_512  = 10'h1FF;
  localparam logic [9:0] WRAP_1024 = 10'h3FF;
  localparam logic [2:0] ERASE_ONE  = 3'h1;
  localparam logic [2:0] ERASE_TWO  = 3'h2;
  localparam logic [2:0] ERASE_FOUR = 3'h4;
  localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_LONG  = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_LONG  = 4'hA;
  localparam logic [7:0] LEARN_PATTERN    = 8'h34;

  typedef struct packed {
    logic       suspend_flag;
    logic       protect_complement;
    logic [2:0] security_locks;
    logic       program_erase_fail_flag;
    logic       quad_enable;
    logic       status_protect_high;
    logic       status_protect_low;
    logic [4:0] block_protect_bits;
    logic       write_enable_latch;
    logic       write_in_progress_flag;
  } fsc_status_s;  // R22

  typedef struct packed {
    logic       hold_reset_select;
    logic [1:0] reserved;
    logic       page_size_select_hi;
    logic       page_size_select_lo;
    logic       protect_scheme_select;
    logic       dummy_count_select;
    logic       learning_pattern_enable;
  } fsc_config_s;

  localparam fsc_status_s STATUS_RESET = 16'h0000;
  localparam fsc_config_s CONFIG_RESET = 8'h00;

  typedef enum logic [0:0] {
    FSC_IDLE = 1'b0,
    FSC_BUSY = 1'b1
  } fsc_state_e;

endpackage

// ---- fsc_regs.sv ----
// Status and configuration register logic behind the serial command link
`timescale 1ns/1ps
module fsc_regs #(
  parameter int WRITE_CYC = fsc_pkg::WRITE_CYCLES
) (
  // System clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Serial link
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  input  wire logic              wp_n_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  // Array engine status
  input  wire logic              array_busy_i,
  input  wire logic              array_done_i,
  input  wire logic              array_fail_i,
  // Configuration outputs
  output fsc_pkg::fsc_status_s   status_o,
  output fsc_pkg::fsc_config_s   config_o,
  output logic                   hold_function_o,
  output logic                   reset_function_o,
  output logic [9:0]             page_wrap_mask_o,
  output logic [2:0]             page_erase_pages_o,
  output logic                   block_lock_scheme_o,
  output logic [3:0]             dual_dummy_clocks_o,
  output logic [3:0]             quad_dummy_clocks_o,
  output logic [7:0]             learning_pattern_o
);
  import fsc_pkg::*;

  // Link domain: frame capture
  logic        fresh;
  logic [5:0]  bit_cnt;
  logic [7:0]  op_sr;
  logic [15:0] data_sr;
  logic [5:0]  next_bit_cnt;
  logic [7:0]  next_op_sr;
  logic [15:0] next_data_sr;

  // Chip select high arms the counter restart without losing the last frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_op_sr   = op_sr;
    next_data_sr = data_sr;
    if (fresh) begin
      next_bit_cnt = LEN_FIRST;
      next_op_sr   = {op_sr[6:0], si_i};
    end else begin
      if (bit_cnt != LEN_MAX) begin
        next_bit_cnt = bit_cnt + LEN_FIRST;
      end
      if (bit_cnt < LEN_OPCODE) begin
        next_op_sr = {op_sr[6:0], si_i};
      end else begin
        next_data_sr = {data_sr[14:0], si_i};
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    bit_cnt <= next_bit_cnt;
    op_sr   <= next_op_sr;
    data_sr <= next_data_sr;
  end

  // Link domain: read data out on the falling edge
  fsc_status_s shadow_status;
  fsc_config_s shadow_config;
  logic [7:0]  read_byte;
  logic        read_op;
  logic        next_so;
  logic        next_so_oe;

  always_comb begin
    read_op   = 1'b1;
    read_byte = shadow_status[7:0];
    case (op_sr)
      OP_READ_STAT_LO: read_byte = shadow_status[7:0];   // R24
      OP_READ_STAT_HI: read_byte = shadow_status[15:8];  // R24
      OP_READ_CONFIG:  read_byte = shadow_config;        // R5
      default:         read_op   = 1'b0;
    endcase
    next_so    = 1'b0;
    next_so_oe = 1'b0;
    if (read_op && !fresh && bit_cnt >= LEN_OPCODE) begin
      next_so    = read_byte[3'h7 - bit_cnt[2:0]];
      next_so_oe = 1'b1;
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_o    <= next_so;
      so_oe_o <= next_so_oe;
    end
  end

  // System domain: synchronisers
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  logic cs_rise;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= wp_n_i;
      wp_sync <= wp_meta;
    end
  end

  assign cs_rise = cs_sync & ~cs_prev;

  // System domain: registers and write cycle
  fsc_state_e  state;
  fsc_state_e  next_state;
  fsc_status_s status_q;
  fsc_status_s next_status;
  fsc_config_s config_q;
  fsc_config_s next_config;
  fsc_status_s pend_status;
  fsc_status_s next_pend_status;
  fsc_config_s pend_config;
  fsc_config_s next_pend_config;
  logic [31:0] timer;
  logic [31:0] next_timer;
  fsc_status_s next_shadow_status;
  fsc_config_s next_shadow_config;
  logic        busy;
  logic        hw_protect;
  logic        write_ok;
  logic [7:0]  byte_a;
  logic [7:0]  byte_b;
  fsc_status_s live_status;

  assign busy       = (state == FSC_BUSY) | array_busy_i;
  assign hw_protect = status_q.status_protect_high |
                      (status_q.status_protect_low & ~wp_sync);  // R19
  assign write_ok   = status_q.write_enable_latch & ~busy & ~hw_protect;  // R14 R23
  assign byte_a     = (bit_cnt == LEN_TWO_BYTE) ? data_sr[15:8] : data_sr[7:0];
  assign byte_b     = data_sr[7:0];

  always_comb begin
    live_status = status_q;
    live_status.write_in_progress_flag = busy;  // R18 R21
  end

  always_comb begin
    next_state         = state;
    next_status        = status_q;
    next_config        = config_q;
    next_pend_status   = pend_status;
    next_pend_config   = pend_config;
    next_timer         = timer;
    next_shadow_status = shadow_status;
    next_shadow_config = shadow_config;
    // Snapshot frozen while a frame runs, so the link never sees it change
    if (cs_sync) begin
      next_shadow_status = live_status;
      next_shadow_config = config_q;
    end
    if (array_done_i) begin
      next_status.program_erase_fail_flag = array_fail_i;  // R1
    end
    if (state == FSC_BUSY) begin
      if (timer == 32'h1) begin
        next_state  = FSC_IDLE;
        next_status = pend_status;
        next_config = pend_config;
        next_status.write_enable_latch = 1'b0;  // R18 R21
        next_status.suspend_flag = status_q.suspend_flag;  // R15
        next_status.program_erase_fail_flag = array_done_i ? array_fail_i :
                                              status_q.program_erase_fail_flag;
      end else begin
        next_timer = timer - 32'h1;
      end
    end
    if (cs_rise) begin
      case (op_sr)
        OP_WRITE_ENABLE: begin
          if (bit_cnt == LEN_OPCODE && !busy) begin
            next_status.write_enable_latch = 1'b1;
          end
        end
        OP_WRITE_DISABLE: begin
          if (bit_cnt == LEN_OPCODE && !busy) begin
            next_status.write_enable_latch = 1'b0;
          end
        end
        OP_SUSPEND: begin
          if (bit_cnt == LEN_OPCODE) begin
            next_status.suspend_flag = 1'b1;  // R4
          end
        end
        OP_RESUME: begin
          if (bit_cnt == LEN_OPCODE) begin
            next_status.suspend_flag = 1'b0;  // R4
          end
        end
        OP_WRITE_STATUS: begin
          if (write_ok && (bit_cnt == LEN_ONE_BYTE || bit_cnt == LEN_TWO_BYTE)) begin  // R16
            next_pend_status = status_q;
            next_pend_config = config_q;
            next_pend_status.status_protect_low = byte_a[7];
            next_pend_status.block_protect_bits = byte_a[6:2];  // R15 R17
            if (bit_cnt == LEN_TWO_BYTE) begin  // R17
              next_pend_status.protect_complement  = byte_b[6];  // R3
              next_pend_status.security_locks      = status_q.security_locks | byte_b[5:3];  // R2
              next_pend_status.quad_enable         = byte_b[1];
              next_pend_status.status_protect_high = byte_b[0];
            end
            next_state = FSC_BUSY;
            next_timer = WRITE_CYC;
          end
        end
        OP_WRITE_STAT_HI: begin
          if (write_ok && bit_cnt == LEN_ONE_BYTE) begin  // R16
            next_pend_status = status_q;
            next_pend_config = config_q;
            next_pend_status.protect_complement  = byte_b[6];  // R3
            next_pend_status.security_locks      = status_q.security_locks | byte_b[5:3];  // R2
            next_pend_status.quad_enable         = byte_b[1];
            next_pend_status.status_protect_high = byte_b[0];  // R15
            next_state = FSC_BUSY;
            next_timer = WRITE_CYC;
          end
        end
        OP_WRITE_CONFIG: begin
          if (write_ok && bit_cnt == LEN_ONE_BYTE) begin  // R20
            next_pend_status = status_q;
            next_pend_config = byte_b;
            next_pend_config.reserved = 2'h0;  // R25
            next_state = FSC_BUSY;
            next_timer = WRITE_CYC;
          end
        end
        default: begin
          next_state = next_state;
        end
      endcase
    end
  end

  // Reset stands for a power cycle: every bit returns to its default
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state         <= FSC_IDLE;
      status_q      <= STATUS_RESET;
      config_q      <= CONFIG_RESET;  // R26
      pend_status   <= STATUS_RESET;
      pend_config   <= CONFIG_RESET;
      timer         <= 32'h0;
      shadow_status <= STATUS_RESET;
      shadow_config <= CONFIG_RESET;
    end else begin
      state         <= next_state;
      status_q      <= next_status;
      config_q      <= next_config;
      pend_status   <= next_pend_status;
      pend_config   <= next_pend_config;
      timer         <= next_timer;
      shadow_status <= next_shadow_status;
      shadow_config <= next_shadow_config;
    end
  end

  // Derived configuration outputs
  fsc_status_s out_status;
  logic        out_hold;
  logic        out_reset;
  logic [9:0]  out_wrap;
  logic [2:0]  out_erase;
  logic [3:0]  out_dual;
  logic [3:0]  out_quad;
  logic [7:0]  out_learn;

  always_comb begin
    out_status = live_status;
    out_hold   = ~config_q.hold_reset_select & ~status_q.quad_enable;  // R7
    out_reset  = config_q.hold_reset_select & ~status_q.quad_enable;   // R7
    case ({config_q.page_size_select_hi, config_q.page_size_select_lo})
      2'h1: begin
        out_wrap  = WRAP_512;  // R8 R9
        out_erase = ERASE_TWO;  // R10
      end
      2'h2: begin
        out_wrap  = WRAP_1024;  // R8 R9
        out_erase = ERASE_FOUR;  // R10
      end
      default: begin
        out_wrap  = WRAP_256;  // R9
        out_erase = ERASE_ONE;
      end
    endcase
    out_dual  = config_q.dummy_count_select ? DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT;  // R12
    out_quad  = config_q.dummy_count_select ? QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT;  // R12
    out_learn = config_q.learning_pattern_enable ? LEARN_PATTERN : 8'h00;  // R13
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_o            <= STATUS_RESET;
      config_o            <= CONFIG_RESET;
      hold_function_o     <= 1'b1;
      reset_function_o    <= 1'b0;
      page_wrap_mask_o    <= WRAP_256;
      page_erase_pages_o  <= ERASE_ONE;
      block_lock_scheme_o <= 1'b0;
      dual_dummy_clocks_o <= DUAL_DUMMY_SHORT;
      quad_dummy_clocks_o <= QUAD_DUMMY_SHORT;
      learning_pattern_o  <= 8'h00;
    end else begin
      status_o            <= out_status;
      config_o            <= config_q;
      hold_function_o     <= out_hold;
      reset_function_o    <= out_reset;
      page_wrap_mask_o    <= out_wrap;
      page_erase_pages_o  <= out_erase;
      block_lock_scheme_o <= config_q.protect_scheme_select;  // R11
      dual_dummy_clocks_o <= out_dual;
      quad_dummy_clocks_o <= out_quad;
      learning_pattern_o  <= out_learn;
    end
  end

  // Checks
  AST_FAIL_FOLLOWS: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R1
    array_done_i |=> status_q.program_erase_fail_flag == $past(array_fail_i))
    else $error("fail flag does not follow array result");

  AST_LOCKS_STICKY: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R2
    ((status_q.security_locks & $past(status_q.security_locks))
      == $past(status_q.security_locks)))
    else $error("security lock bit returned to zero");

  AST_SUSPEND_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R4
    cs_rise && op_sr == OP_SUSPEND && bit_cnt == LEN_OPCODE |=> status_q.suspend_flag)
    else $error("suspend flag not set");

  AST_NEEDS_LATCH: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R23
    state == FSC_IDLE && !status_q.write_enable_latch |=> state == FSC_IDLE)
    else $error("write cycle without write enable latch");

  AST_PROTECT_REFUSE: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R19
    state == FSC_IDLE && hw_protect |=> state == FSC_IDLE)
    else $error("write cycle in hardware protected mode");

  AST_BUSY_SHOWN: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R18
    state == FSC_BUSY |=> status_o.write_in_progress_flag)
    else $error("busy flag low during write cycle");

  AST_LATCH_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R21
    state == FSC_BUSY ##1 state == FSC_IDLE |-> !status_q.write_enable_latch)
    else $error("write enable latch not cleared after write cycle");

  AST_KEEP_S15_S10: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R15
    state == FSC_BUSY && timer == 32'h1 && !cs_rise && !array_done_i |=>
      $stable(status_q.suspend_flag) && $stable(status_q.program_erase_fail_flag))
    else $error("status write changed protected bits");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R25
    config_q.reserved == 2'h0)
    else $error("reserved configuration bits not zero");

  AST_WRAP_MAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R9
    {config_q.page_size_select_hi, config_q.page_size_select_lo} == 2'h0 |=>
      page_wrap_mask_o == WRAP_256)
    else $error("wrong wrap point for default page size");

endmodule // fsc_regs

// ---- fsc_host_model.sv ----
// Behavioural host controller on the far side of the serial command link
`timescale 1ns/1ps
module fsc_host_model (
  // Serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  import fsc_pkg::*;

  localparam int HALF_NS = 80;
  localparam int GAP_NS  = 1000;

  // Chip select starts low and rises once, so the link-side flops see a real edge
  // Setting it high at time zero alone could race the design's first process
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    si_o   = 1'b1;
    #1;
    cs_n_o = 1'b1;
  end

  // Opcode then data, MSB first; clock stands low outside frames
  // Chip select rises only after the bit count asked for
  task automatic xfer(input logic [7:0] op, input logic [15:0] data, input int nbits,
                      output logic [7:0] rd);
    logic [23:0] sr;
    sr = {op, data};
    rd = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o = sr[23 - i];
      #(HALF_NS);
      sclk_o = 1'b1;
      if (i >= 8 && i < 16) begin
        rd = {rd[6:0], so_i};
      end
      #(HALF_NS);
      sclk_o = 1'b0;
    end
    #(HALF_NS);
    cs_n_o = 1'b1;
    // Released data line must not keep its last value
    si_o = ~si_o;
    #(GAP_NS);
  endtask

  // One snapshot per read frame, so polling needs fresh frames
  task automatic poll_idle(output logic idle);
    logic [7:0] st;
    idle = 1'b0;
    for (int k = 0; k < 8 && !idle; k++) begin
      xfer(OP_READ_STAT_LO, 16'h0000, 16, st);
      idle = (st[0] === 1'b0);
    end
  endtask
endmodule // fsc_host_model

// ---- fsc_regs_tb_top.sv ----
// Self-checking bench for the status and configuration register block
`timescale 1ns/1ps
module fsc_regs_tb_top;
  import fsc_pkg::*;

  logic        clk_i, sys_rst_i, wp_n_i, sclk, cs_n, si, so, so_oe, so_line;
  logic        array_busy_i, array_done_i, array_fail_i;
  fsc_status_s status;
  fsc_config_s cfg;
  logic        hold_fn, reset_fn, lock_scheme, idle;
  logic [9:0]  wrap;
  logic [2:0]  erase_pages;
  logic [3:0]  dual_dc, quad_dc;
  logic [7:0]  pattern, rd;
  int          err_count, checked;

  // Released output reads high: so_o is held at 0 whenever so_oe_o is 0
  assign so_line = so_oe ? so : ~so;

  fsc_regs #(.WRITE_CYC(20)) u_fsc_regs (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .array_busy_i(array_busy_i),
    .array_done_i(array_done_i), .array_fail_i(array_fail_i), .status_o(status),
    .config_o(cfg), .hold_function_o(hold_fn), .reset_function_o(reset_fn),
    .page_wrap_mask_o(wrap), .page_erase_pages_o(erase_pages),
    .block_lock_scheme_o(lock_scheme), .dual_dummy_clocks_o(dual_dc),
    .quad_dummy_clocks_o(quad_dc), .learning_pattern_o(pattern));

  fsc_host_model u_fsc_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] op, input logic [7:0] exp);
    u_fsc_host_model.xfer(op, 16'h0000, 16, rd);
    chk("link read", {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] data, input int nbits);
    u_fsc_host_model.xfer(op, data, nbits, rd);
  endtask

  // Enable, command, then wait out the timed cycle
  task automatic wr(input logic [7:0] op, input logic [15:0] data, input int nbits);
    cmd(OP_WRITE_ENABLE, 16'h0000, 8);
    cmd(op, data, nbits);
    u_fsc_host_model.poll_idle(idle);
    if (idle !== 1'b1) begin
      err_count++;
      $display("Error busy flag expected 0 seen 1");
      report_and_stop();
    end
  endtask

  task automatic t_reset();
    chk("status", 16'h0000, status);
    chk("config", 16'h0000, {8'h00, cfg});
    chk_rd(OP_READ_CONFIG, 8'h00);
    chk_rd(OP_READ_STAT_LO, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_no_latch();
    cmd(OP_WRITE_STATUS, 16'h8400, 16);
    cmd(OP_WRITE_CONFIG, 16'h0800, 16);
    chk("status", 16'h0000, status);
    chk("config", 16'h0000, {8'h00, cfg});
    $display("t_no_latch done");
  endtask

  task automatic t_config();
    logic [7:0]  din [3] = '{8'h68, 8'hF7, 8'h00};
    logic [7:0]  c;
    logic [15:0] ew, ed;
    for (int i = 0; i < 3; i++) begin
      c = din[i] & 8'h9F;
      ew = {c[4] ? WRAP_1024 : (c[3] ? WRAP_512 : WRAP_256),
            c[4] ? ERASE_FOUR : (c[3] ? ERASE_TWO : ERASE_ONE), c[2], ~c[7], c[7]};
      ed = {c[1] ? DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT,
            c[1] ? QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT, c[0] ? LEARN_PATTERN : 8'h00};
      wr(OP_WRITE_CONFIG, {din[i], 8'h00}, 16);
      chk("config", {8'h00, c}, {8'h00, cfg});
      chk_rd(OP_READ_CONFIG, c);
      chk("page and pin", ew, {wrap, erase_pages, lock_scheme, hold_fn, reset_fn});
      chk("dummy", ed, {dual_dc, quad_dc, pattern});
      chk("status", 16'h0000, status);
    end
    $display("t_config done");
  endtask

  task automatic t_low_byte();
    cmd(OP_WRITE_ENABLE, 16'h0000, 8);
    chk("status", 16'h0002, status);
    cmd(OP_WRITE_STATUS, 16'hFF00, 16);
    chk_rd(OP_READ_STAT_LO, 8'h03);
    u_fsc_host_model.poll_idle(idle);
    chk("status", 16'h00FC, status);
    chk_rd(OP_READ_STAT_HI, 8'h00);
    $display("t_low_byte done");
  endtask

  task automatic t_two_byte();
    wr(OP_WRITE_STATUS, 16'h007A, 24);
    chk("status", 16'h7A00, status);
    chk("pin", 16'h0000, {14'h0000, hold_fn, reset_fn});
    chk_rd(OP_READ_STAT_HI, 8'h7A);
    $display("t_two_byte done");
  endtask

  task automatic t_bad_len();
    cmd(OP_WRITE_ENABLE, 16'h0000, 8);
    cmd(OP_WRITE_STATUS, 16'hFFFF, 20);
    cmd(OP_WRITE_CONFIG, 16'hFFFF, 24);
    chk("status", 16'h7A02, status);
    chk("config", 16'h0000, {8'h00, cfg});
    wr(OP_WRITE_STAT_HI, 16'h0000, 16);
    chk("status", 16'h3800, status);
    $display("t_bad_len done");
  endtask

  task automatic t_suspend();
    cmd(OP_SUSPEND, 16'h0000, 8);
    chk_rd(OP_READ_STAT_HI, 8'hB8);
    wr(OP_WRITE_STATUS, 16'h0000, 24);
    chk("status", 16'hB800, status);
    cmd(OP_RESUME, 16'h0000, 8);
    chk("status", 16'h3800, status);
    $display("t_suspend done");
  endtask

  task automatic t_hw_protect();
    wr(OP_WRITE_STATUS, 16'h8000, 16);
    @(negedge clk_i);
    wp_n_i = 1'b0;
    wr(OP_WRITE_STATUS, 16'h0400, 16);
    chk("status", 16'h3882, status);
    @(negedge clk_i);
    wp_n_i = 1'b1;
    wr(OP_WRITE_STATUS, 16'h0000, 16);
    chk("status", 16'h3800, status);
    $display("t_hw_protect done");
  endtask

  task automatic t_fail();
    @(negedge clk_i);
    array_done_i = 1'b1;
    array_fail_i = 1'b1;
    @(negedge clk_i);
    array_done_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("status", 16'h3C00, status);
    wr(OP_WRITE_STATUS, 16'h0000, 24);
    chk("status", 16'h3C00, status);
    @(negedge clk_i);
    array_done_i = 1'b1;
    array_fail_i = 1'b0;
    @(negedge clk_i);
    array_done_i = 1'b0;
    array_busy_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("status", 16'h3801, status);
    array_busy_i = 1'b0;
    $display("t_fail done");
  endtask

  task automatic t_power();
    wr(OP_WRITE_CONFIG, 16'h1B00, 16);
    chk("config", 16'h001B, {8'h00, cfg});
    chk("page and pin", {WRAP_256, ERASE_ONE, 3'h2}, {wrap, erase_pages, lock_scheme, hold_fn, reset_fn});
    chk("dummy", {DUAL_DUMMY_LONG, QUAD_DUMMY_LONG, LEARN_PATTERN}, {dual_dc, quad_dc, pattern});
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("config", 16'h0000, {8'h00, cfg});
    chk("status", 16'h0000, status);
    chk("dummy", {DUAL_DUMMY_SHORT, QUAD_DUMMY_SHORT, 8'h00}, {dual_dc, quad_dc, pattern});
    $display("t_power done");
  endtask

  initial begin
    err_count = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    wp_n_i = 1'b1;
    array_busy_i = 1'b0;
    array_done_i = 1'b0;
    array_fail_i = 1'b0;
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    t_reset();
    t_no_latch();
    t_config();
    t_low_byte();
    t_two_byte();
    t_bad_len();
    t_suspend();
    t_hw_protect();
    t_fail();
    t_power();
    report_and_stop();
  end

  // Hang guard
  initial begin
    #(4000000);
    err_count++;
    $display("Error watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule // fsc_regs_tb_top
